// ===== pkg/cxa_params.svh
// Constants for the coexistence arbitration signalling block
`ifndef CXA_PARAMS_SVH
`define CXA_PARAMS_SVH
`define CXA_ADDR_CTRL     8'h00
`define CXA_ADDR_STATUS   8'h04
`define CXA_ADDR_RAND     8'h08
`define CXA_CTRL_RST      32'h0000_0000
`define CXA_MASK_RST      8'h00
`define CXA_RAND_SEED     16'hACE1
`define CXA_CLK_MHZ       200
`define CXA_US_CYCLES     (`CXA_CLK_MHZ)
`define CXA_RESP_OKAY     2'b00
`define CXA_RESP_SLVERR   2'b10
`endif

// ===== pkg/cxa_pkg.sv
// Types for the coexistence arbitration signalling block
package cxa_pkg;
    typedef enum logic [1:0]
    {
        CXA_IDLE   = 2'b00,
        CXA_BACKOFF = 2'b01,
        CXA_REQ    = 2'b11,
        CXA_TX     = 2'b10
    } cxa_state_t;

    typedef struct packed
    {
        logic [7:0] backoff_mask;
        logic       tx_prio;
        logic       ack_suppress;
        logic       abort_on_loss;
        logic       rho_active_high;
        logic       rho_enable;
        logic       grant_active_high;
        logic       grant_enable;
        logic       req_shared;
        logic       req_active_high;
        logic       req_enable;
    } cxa_cfg_t;

    typedef struct packed
    {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cxa_axi_req_t;

    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cxa_axi_rsp_t;
endpackage

// ===== testbench/coex_arbitration_signals_bench.sv
// Self-checking bench for the arbitration signalling block
`timescale 1ns/1ps
`default_nettype none
`include "cxa_params.svh"
module coex_arbitration_signals_bench
    import cxa_pkg::*;
;
    logic         aclk;
    logic         aresetn;
    cxa_axi_req_t rq;
    cxa_axi_rsp_t rs;
    logic         tx_start, tx_done, cca_done, ack_pending;
    logic         tx_go, tx_abort, ack_allow, prio_out;
    logic         grant_pin, rho_pin, req_wire, req_out, req_oe;
    logic         g_lvl, r_lvl, g_hi, r_hi, p_lvl;
    logic [31:0]  seed;
    logic [31:0]  rd;
    logic [1:0]   rr;
    logic [1:0]   br;
    int           num_errors;
    int           check_count;
    int           cyc;

    cxa_arbiter dut
    (
        .aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
        .tx_start(tx_start), .tx_done(tx_done), .cca_done(cca_done),
        .ack_pending(ack_pending), .tx_go(tx_go), .tx_abort(tx_abort),
        .ack_allow(ack_allow), .grant_pin(grant_pin),
        .radio_hold_off_pin(rho_pin), .req_pin_in(req_wire),
        .req_pin_out(req_out), .req_pin_oe(req_oe), .prio_out(prio_out)
    );

    cxa_wlan_model far
    (
        .gnt(g_lvl), .radio_hold_off(r_lvl), .gnt_hi(g_hi), .rho_hi(r_hi),
        .pull_lvl(p_lvl), .req_out(req_out), .req_oe(req_oe),
        .req_wire(req_wire), .grant_pin(grant_pin), .rho_pin(rho_pin)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        rq.awvalid <= 1'b1;
        rq.awaddr  <= a;
        rq.wvalid  <= 1'b1;
        rq.wdata   <= d;
        rq.wstrb   <= 4'hF;
        rq.bready  <= 1'b1;
        while (rs.bvalid !== 1'b1)
        begin
            @(posedge aclk);
            if (rs.awready === 1'b1) rq.awvalid <= 1'b0;
            if (rs.wready === 1'b1) rq.wvalid <= 1'b0;
        end
        br = rs.bresp;
        rq.bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        rq.arvalid <= 1'b1;
        rq.araddr  <= a;
        rq.rready  <= 1'b1;
        while (rs.rvalid !== 1'b1)
        begin
            @(posedge aclk);
            if (rs.arready === 1'b1) rq.arvalid <= 1'b0;
        end
        rd = rs.rdata;
        rr = rs.rresp;
        rq.rready <= 1'b0;
    endtask

    task automatic pulse_done();
        @(posedge aclk) tx_done <= 1'b1;
        @(posedge aclk) tx_done <= 1'b0;
    endtask

    // One transmit attempt under configuration c
    task automatic tx_case(input logic [15:0] c, input logic g, input logic r);
        logic ge, ho, go, ab;
        int k;
        ge = !c[3] | g;
        ho = c[5] & r;
        g_lvl <= g;
        r_lvl <= r;
        g_hi  <= c[4];
        r_hi  <= c[6];
        p_lvl <= !c[1];
        axi_wr(`CXA_ADDR_CTRL, {16'h0000, c});
        repeat (6) @(posedge aclk);
        axi_rd(`CXA_ADDR_STATUS);
        chk(32'(rd[3:2]), 32'({ho, ge}));
        @(posedge aclk) tx_start <= 1'b1;
        @(posedge aclk) tx_start <= 1'b0;
        k = 0;
        while (k < 700 && ((c[0] && !ho) ? req_wire !== c[1] : c[2]))
        begin
            @(posedge aclk);
            k++;
        end
        repeat (2) @(posedge aclk);
        if (c[0] && !ho) chk(32'({req_oe, req_out}), 32'({1'b1, c[1]}));
        if (!c[0]) chk(32'(req_oe), 32'h0);
        @(posedge aclk) cca_done <= 1'b1;
        @(posedge aclk) cca_done <= 1'b0;
        go = 1'b0;
        ab = 1'b0;
        for (k = 0; k < 10 && !go && !ab; k++)
        begin
            @(posedge aclk);
            go = (tx_go === 1'b1);
            ab = (tx_abort === 1'b1);
        end
        if (c[0]) chk(32'(go), 32'(ge & !ho));
        if (!go) chk(32'(ack_allow), 32'(ack_pending & !c[8]));
        if (go)
        begin
            chk(32'(prio_out), 32'(c[9]));
            chk(32'(ack_allow),
                32'(ack_pending & (!c[8] | !c[2] | c[0])));
            if (c[3])
            begin
                g_lvl <= 1'b0;
                ab = 1'b0;
                repeat (10) @(posedge aclk) ab = ab | (tx_abort === 1'b1);
                chk(32'(ab), 32'(c[7]));
            end
        end
        pulse_done();
        repeat (4) @(posedge aclk);
        if (c[0]) chk(32'({req_oe, req_wire}), 32'({!c[2], !c[1]}));
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        aresetn = 1'b0;
        rq = '0;
        tx_start = 1'b0;
        tx_done = 1'b0;
        cca_done = 1'b0;
        ack_pending = 1'b1;
        g_lvl = 1'b1;
        r_lvl = 1'b0;
        g_hi = 1'b1;
        r_hi = 1'b1;
        p_lvl = 1'b1;
        seed = 32'h67A8;
        num_errors = 0;
        check_count = 0;
        cyc = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`CXA_ADDR_CTRL);
        chk(rd, `CXA_CTRL_RST);
        axi_rd(8'h0C);
        chk(32'(rr), 32'(`CXA_RESP_SLVERR));
        chk(rd, 32'h0);
        axi_wr(8'h0C, 32'h0);
        chk(32'(br), 32'(`CXA_RESP_SLVERR));
        axi_wr(`CXA_ADDR_CTRL, 32'hFFFF_FFFF);
        chk(32'(br), 32'(`CXA_RESP_OKAY));
        axi_rd(`CXA_ADDR_CTRL);
        chk(rd, 32'h0000_FFFF);
        for (int i = 0; i < 8; i++)
            tx_case(16'(i), 1'b1, 1'b0);
        repeat (40)
        begin
            seed = xs(seed);
            ack_pending <= seed[18];
            tx_case(seed[15:0] & 16'h0FFF, seed[16], seed[17]);
        end
        final_report();
    end
endmodule
`default_nettype wire

// ===== testbench/cxa_wlan_model.sv
// Far-side arbiter model: grant, hold-off and request wire
`timescale 1ns/1ps
`default_nettype none
module cxa_wlan_model
(
    // Bench control
    input  wire logic gnt,
    input  wire logic radio_hold_off,
    input  wire logic gnt_hi,
    input  wire logic rho_hi,
    input  wire logic pull_lvl,
    // Request line
    input  wire logic req_out,
    input  wire logic req_oe,
    output var  logic req_wire,
    // Arbiter pins
    output var  logic grant_pin,
    output var  logic rho_pin
);
    assign grant_pin = gnt ~^ gnt_hi;
    assign rho_pin   = radio_hold_off ~^ rho_hi;
    assign req_wire  = req_oe ? req_out : pull_lvl;
endmodule
`default_nettype wire

// ===== verilog/cxa_arbiter.sv
// Requester-side packet traffic arbitration signalling with AXI4-Lite
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cxa_params.svh"
module cxa_arbiter
    import cxa_pkg::*;
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // AXI4-Lite slave
    input  wire cxa_axi_req_t axi_req,
    output var  cxa_axi_rsp_t axi_rsp,
    // Radio core side
    input  wire logic         tx_start,
    input  wire logic         tx_done,
    input  wire logic         cca_done,
    input  wire logic         ack_pending,
    output var  logic         tx_go,
    output var  logic         tx_abort,
    output var  logic         ack_allow,
    // Arbitration pins
    input  wire logic         grant_pin,
    input  wire logic         radio_hold_off_pin,
    input  wire logic         req_pin_in,
    output var  logic         req_pin_out,
    output var  logic         req_pin_oe,
    output var  logic         prio_out
);
    typedef struct packed
    {
        cxa_state_t   st;
        cxa_cfg_t     cfg;
        cxa_axi_rsp_t rsp;
        logic [15:0]  lfsr;
        logic [7:0]   us_left;
        logic [7:0]   cyc;
        logic         req_asserted;
        logic         granted;
        logic         rho_q;
        logic         secured;
        logic         tx_go;
        logic         tx_abort;
        logic         ack_allow;
        logic         req_out;
        logic         req_oe;
        logic         prio;
    } cxa_regs_t;

    cxa_regs_t  s_reg;
    cxa_regs_t  s_next;
    logic [2:0] pin_raw;
    logic [2:0] pin_sync;
    logic       grant_eff;
    logic       rho_eff;

    default clocking cb_chk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    assign pin_raw = {req_pin_in, radio_hold_off_pin, grant_pin};
    for (genvar i = 0; i < 3; i++)
    begin : g_sync
        cxa_sync u_sync
        (
            .aclk    (aclk),
            .aresetn (aresetn),
            .d_in    (pin_raw[i]),
            .q_out   (pin_sync[i])
        );
    end

    function automatic logic [31:0] cfg_word(input cxa_cfg_t c);
        cfg_word = {16'h0000, c[15:8], c[7:0]};
    endfunction

    assign grant_eff = !s_reg.cfg.grant_enable ||
                       (pin_sync[0] == s_reg.cfg.grant_active_high);
    assign rho_eff = s_reg.cfg.rho_enable &&
                     (pin_sync[1] == s_reg.cfg.rho_active_high);

    always_comb
    begin
        s_next = s_reg;
        s_next.tx_go    = 1'b0;
        s_next.tx_abort = 1'b0;
        s_next.rho_q    = rho_eff;
        s_next.lfsr = {s_reg.lfsr[14:0], s_reg.lfsr[15] ^ s_reg.lfsr[13]
                       ^ s_reg.lfsr[12] ^ s_reg.lfsr[10]};
        // AXI write: address and data together
        s_next.rsp.awready = 1'b0;
        s_next.rsp.wready  = 1'b0;
        if (s_reg.rsp.bvalid && axi_req.bready)
            s_next.rsp.bvalid = 1'b0;
        if (axi_req.awvalid && axi_req.wvalid && !s_reg.rsp.bvalid
            && !s_reg.rsp.awready)
        begin
            s_next.rsp.awready = 1'b1;
            s_next.rsp.wready  = 1'b1;
            s_next.rsp.bvalid  = 1'b1;
            if (axi_req.awaddr == `CXA_ADDR_CTRL)
            begin
                s_next.rsp.bresp = `CXA_RESP_OKAY;
                if (axi_req.wstrb[0])
                    s_next.cfg[7:0] = axi_req.wdata[7:0];
                if (axi_req.wstrb[1])
                    s_next.cfg[15:8] = axi_req.wdata[15:8];
            end
            else if (axi_req.awaddr == `CXA_ADDR_STATUS)
                s_next.rsp.bresp = `CXA_RESP_OKAY;
            else
                s_next.rsp.bresp = `CXA_RESP_SLVERR;
        end
        // AXI read
        s_next.rsp.arready = 1'b0;
        if (s_reg.rsp.rvalid && axi_req.rready)
            s_next.rsp.rvalid = 1'b0;
        if (axi_req.arvalid && !s_reg.rsp.rvalid && !s_reg.rsp.arready)
        begin
            s_next.rsp.arready = 1'b1;
            s_next.rsp.rvalid  = 1'b1;
            s_next.rsp.rresp   = `CXA_RESP_OKAY;
            if (axi_req.araddr == `CXA_ADDR_CTRL)
                s_next.rsp.rdata = cfg_word(s_reg.cfg);
            else if (axi_req.araddr == `CXA_ADDR_STATUS)
                s_next.rsp.rdata = {24'h000000, s_reg.st, s_reg.secured,
                                    s_reg.granted, s_reg.rho_q,
                                    grant_eff, s_reg.req_asserted,
                                    s_reg.ack_allow};
            else if (axi_req.araddr == `CXA_ADDR_RAND)
                s_next.rsp.rdata = {16'h0000, s_reg.lfsr};
            else
            begin
                s_next.rsp.rdata = 32'h0000_0000;
                s_next.rsp.rresp = `CXA_RESP_SLVERR;
            end
        end
        // Request sequencing
        case (s_reg.st)
            CXA_IDLE:
            begin
                s_next.req_asserted = 1'b0;
                s_next.granted      = 1'b0;
                if (tx_start && s_reg.cfg.req_shared)
                begin
                    s_next.us_left = s_reg.lfsr[7:0] & s_reg.cfg.backoff_mask;
                    s_next.cyc     = 8'h00;
                    s_next.st      = CXA_BACKOFF;
                end
                else if (tx_start)
                begin
                    s_next.req_asserted = 1'b1;
                    s_next.st           = CXA_REQ;
                end
            end
            CXA_BACKOFF:
            begin
                if (s_reg.us_left == 8'h00)
                begin
                    s_next.req_asserted = 1'b1;
                    s_next.st           = CXA_REQ;
                end
                else if (s_reg.cyc == 8'(`CXA_US_CYCLES - 1))
                begin
                    s_next.cyc     = 8'h00;
                    s_next.us_left = s_reg.us_left - 8'h01;
                end
                else
                    s_next.cyc = s_reg.cyc + 8'h01;
            end
            CXA_REQ:
            begin
                if (cca_done && grant_eff && !rho_eff)
                begin
                    s_next.granted = 1'b1;
                    s_next.tx_go   = 1'b1;
                    s_next.st      = CXA_TX;
                end
                else if (cca_done)
                begin
                    s_next.tx_abort = 1'b1;
                    s_next.st       = CXA_IDLE;
                end
            end
            CXA_TX:
            begin
                if (s_reg.cfg.abort_on_loss && !grant_eff)
                begin
                    s_next.tx_abort = 1'b1;
                    s_next.st       = CXA_IDLE;
                end
                else if (tx_done)
                    s_next.st = CXA_IDLE;
            end
            default:
                s_next.st = CXA_IDLE;
        endcase
        // Request secured on shared line
        s_next.secured = s_reg.req_asserted &&
                         (!s_reg.cfg.req_shared ||
                          (pin_sync[2] == s_reg.cfg.req_active_high));
        s_next.ack_allow = ack_pending && (!s_reg.cfg.ack_suppress ||
                           (grant_eff && !rho_eff &&
                            (!s_reg.cfg.req_shared || s_reg.secured)));
        s_next.prio = (s_next.st == CXA_TX) && s_reg.cfg.tx_prio;
        s_next.req_out = s_next.req_asserted ~^ s_reg.cfg.req_active_high;
        if (!s_reg.cfg.req_enable)
            s_next.req_oe = 1'b0;
        else if (!s_reg.cfg.req_shared)
            s_next.req_oe = 1'b1;
        else
            s_next.req_oe = s_next.req_asserted;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_reg     <= '0;
            s_reg.cfg <= cxa_cfg_t'(18'(`CXA_CTRL_RST));
            s_reg.lfsr <= `CXA_RAND_SEED;
        end
        else
            s_reg <= s_next;
    end

    assign axi_rsp     = s_reg.rsp;
    assign tx_go       = s_reg.tx_go;
    assign tx_abort    = s_reg.tx_abort;
    assign ack_allow   = s_reg.ack_allow;
    assign req_pin_out = s_reg.req_out;
    assign req_pin_oe  = s_reg.req_oe;
    assign prio_out    = s_reg.prio;

    property p_req_off;
        !s_reg.cfg.req_enable |=> !req_pin_oe;
    endproperty
    a_req_off: assert property (p_req_off) else $error("req on");
    property p_pushpull;
        s_reg.cfg.req_enable && !s_reg.cfg.req_shared |=> req_pin_oe;
    endproperty
    a_pushpull: assert property (p_pushpull) else $error("no drive");
    property p_shared_rel;
        s_reg.cfg.req_shared |=>
            req_pin_oe == (s_reg.req_asserted && $past(s_reg.cfg.req_enable));
    endproperty
    a_shared_rel: assert property (p_shared_rel) else $error("rel");
    property p_shared_lvl;
        s_reg.cfg.req_shared |=>
            !req_pin_oe || req_pin_out == $past(s_reg.cfg.req_active_high);
    endproperty
    a_shared_lvl: assert property (p_shared_lvl) else $error("lvl");
    property p_abort;
        s_reg.st == CXA_TX && s_reg.cfg.abort_on_loss && !grant_eff
            |=> tx_abort && s_reg.st == CXA_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_noabort;
        s_reg.st == CXA_TX && !s_reg.cfg.abort_on_loss |=> !tx_abort;
    endproperty
    a_noabort: assert property (p_noabort) else $error("bad abort");
    property p_ack;
        s_reg.cfg.ack_suppress && (!grant_eff || rho_eff) |=> !ack_allow;
    endproperty
    a_ack: assert property (p_ack) else $error("ack allowed");
    property p_rho;
        !s_reg.cfg.rho_enable |=> !s_reg.rho_q;
    endproperty
    a_rho: assert property (p_rho) else $error("hold-off seen");
    property p_prio;
        s_reg.st == CXA_TX && $stable(s_reg.st) |->
            prio_out == $past(s_reg.cfg.tx_prio);
    endproperty
    a_prio: assert property (p_prio) else $error("priority wrong");
    sequence s_cca_clear;
        s_reg.st == CXA_REQ && cca_done && grant_eff && !rho_eff;
    endsequence
    sequence s_tx_granted;
        tx_go && s_reg.st == CXA_TX && s_reg.granted;
    endsequence
    property p_cca_go;
        s_cca_clear |=> s_tx_granted;
    endproperty
    a_cca_go: assert property (p_cca_go) else $error("no go");
endmodule
`default_nettype wire

// ===== verilog/cxa_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module cxa_sync
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Data
    input  wire logic d_in,
    output var  logic q_out
);
    logic meta_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_reg <= 1'b0;
            q_out    <= 1'b0;
        end
        else
        begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule
`default_nettype wire
